// *** include/card_host_pkg.sv ***
// constants for the card host status flag block
// Notes on behaviour
// RULE_01: command flag low while busy, set done
// RULE_02: rx flag set on data, cleared by read
// RULE_03: tx flag set on shift load, cleared write
// RULE_04: block ended per write block, clear on read
// RULE_05: in-progress high until crc16 ends
// RULE_06: card holds dat0 low; free after busy
// RULE_07: reads clear free flag at command end
// RULE_08: open-ended read frees on stop command
// RULE_09: single read frees at block end
// RULE_10: counted read frees after last block
// RULE_11: rx count end at zero, cleared counter write
// RULE_12: tx count end at zero, cleared counter write
// RULE_13: rx full while both rx counters zero
// RULE_14: tx empty while both tx counters zero
// RULE_15: slot a irq sticky, cleared status read
// RULE_16: read wait bit follows io wait state
// RULE_17: completion seen sticky, cleared status read
// RULE_18: index error set mismatch, cleared command write
// RULE_19: unused bits read zero, writes ignored
package card_host_pkg;
  localparam logic [31:0] STATUS_ADDR = 32'h40000040;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h40000044;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'h40000048;
  localparam logic [31:0] STATUS_RESET = 32'h00000025;
  localparam int B_CMD_DONE = 0;
  localparam int B_RX_RDY = 1;
  localparam int B_TX_TAKEN = 2;
  localparam int B_BLK_END = 3;
  localparam int B_XFER = 4;
  localparam int B_FREE = 5;
  localparam int B_RX_END = 6;
  localparam int B_TX_END = 7;
  localparam int B_SLOT_A = 8;
  localparam int B_RWAIT = 12;
  localparam int B_CSEEN = 13;
  localparam int B_RX_FULL = 14;
  localparam int B_TX_EMPTY = 15;
  localparam int B_RIDX = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RD_SINGLE = 2'b00,
    RD_COUNTED = 2'b01,
    RD_OPEN = 2'b10,
    WR_BLOCKS = 2'b11
  } xfer_kind_t;
endpackage

// *** rtl/card_host_status_flags.sv ***
// status flag register of the card host, with axi4-lite slave
`timescale 1ns/100ps
module card_host_status_flags (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        i_cmd_write,
  input  wire logic        i_cmd_sent,
  input  wire logic        i_resp_end,
  input  wire logic [5:0]  i_cmd_index,
  input  wire logic [5:0]  i_resp_index,
  input  wire logic [1:0]  i_xfer_kind,
  input  wire logic        i_stop_cmd_end,
  input  wire logic        i_rx_data_read,
  input  wire logic        i_rx_data_arrive,
  input  wire logic        i_tx_data_write,
  input  wire logic        i_tx_shift_load,
  input  wire logic        i_xfer_start,
  input  wire logic        i_crc_end,
  input  wire logic        i_block_end,
  input  wire logic        i_last_block,
  input  wire logic        i_link_clk,
  input  wire logic        i_dat0,
  input  wire logic        i_cmd_line,
  input  wire logic        i_slot_a_irq,
  input  wire logic        i_io_wait,
  input  wire logic        i_rx_cnt_write,
  input  wire logic        i_rx_cnt_zero,
  input  wire logic        i_rx_next_zero,
  input  wire logic        i_tx_cnt_write,
  input  wire logic        i_tx_cnt_zero,
  input  wire logic        i_tx_next_zero,
  output logic             o_irq,
  output logic [31:0]      o_status
);
  // pin samplers: first stage read only by second
  logic [3:0] pin_m_q;
  logic [3:0] pin_s_q;
  logic [3:0] pin_d;
  logic       clk_prev_q;
  logic       clk_prev_d;
  always_comb begin
    pin_d = {i_link_clk, i_dat0, i_cmd_line, i_slot_a_irq};
    clk_prev_d = pin_s_q[3];
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pin_m_q <= 4'hF;
      pin_s_q <= 4'hF;
      clk_prev_q <= 1'b1;
    end else begin
      pin_m_q <= pin_d;
      pin_s_q <= pin_m_q;
      clk_prev_q <= clk_prev_d;
    end
  end
  logic link_rise;
  logic dat0_s;
  logic cmdl_s;
  logic slot_s;
  assign link_rise = pin_s_q[3] & ~clk_prev_q;
  assign dat0_s = pin_s_q[2];
  assign cmdl_s = pin_s_q[1];
  assign slot_s = pin_s_q[0];

  // axi4-lite slave: one write and one read at a time
  typedef enum logic [1:0] {
    SEL_STATUS = 2'b00,
    SEL_MASK   = 2'b01,
    SEL_IRQS   = 2'b10,
    SEL_NONE   = 2'b11
  } reg_sel_t;
  // one decoder for both channels keeps the maps equal
  function automatic reg_sel_t reg_decode(input logic [31:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == card_host_pkg::STATUS_ADDR) begin
      sel = SEL_STATUS;
    end else if (addr == card_host_pkg::IRQ_MASK_ADDR) begin
      sel = SEL_MASK;
    end else if (addr == card_host_pkg::IRQ_STAT_ADDR) begin
      sel = SEL_IRQS;
    end
    return sel;
  endfunction

  logic        aw_q;
  logic        aw_d;
  logic        w_q;
  logic        w_d;
  logic        b_q;
  logic        b_d;
  logic        r_q;
  logic        r_d;
  logic [31:0] awa_q;
  logic [31:0] awa_d;
  logic [31:0] wd_q;
  logic [31:0] wd_d;
  logic [3:0]  ws_q;
  logic [3:0]  ws_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  logic [31:0] irqs_q;
  logic [31:0] irqs_d;
  logic        wr_fire;
  logic        rd_fire;
  logic        status_read;
  reg_sel_t    aw_sel;
  reg_sel_t    ar_sel;
  assign s_axi_awready = ~aw_q & ~b_q;
  assign s_axi_wready = ~w_q & ~b_q;
  assign s_axi_arready = ~r_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_q & w_q & ~b_q;
  assign rd_fire = s_axi_arvalid & ~r_q;
  // write decode uses the held address, read the live one
  assign aw_sel = reg_decode(awa_q);
  assign ar_sel = reg_decode(s_axi_araddr);
  // side effects of reading status: sticky flags clear
  assign status_read = rd_fire & (ar_sel == SEL_STATUS);

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    r_d = r_q;
    awa_d = awa_q;
    wd_d = wd_q;
    rd_d = rd_q;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    mask_d = mask_q;
    ws_d = ws_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = card_host_pkg::RESP_OKAY;
      unique case (aw_sel)
        // strobes held with the data; partial mask writes dropped
        SEL_MASK: begin
          if (ws_q == 4'hF) begin
            mask_d = wd_q;
          end
        end
        // RULE_19 status writes ignored
        SEL_STATUS: begin
          mask_d = mask_q;
        end
        SEL_IRQS: begin
          mask_d = mask_q;
        end
        SEL_NONE: begin
          bresp_d = card_host_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (rd_fire) begin
      r_d = 1'b1;
      rresp_d = card_host_pkg::RESP_OKAY;
      unique case (ar_sel)
        SEL_STATUS: rd_d = stat_q;
        SEL_MASK:   rd_d = mask_q;
        SEL_IRQS:   rd_d = irqs_q;
        SEL_NONE: begin
          rd_d = 32'h00000000;
          rresp_d = card_host_pkg::RESP_SLVERR;
        end
      endcase
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awa_q <= 32'h00000000;
      wd_q <= 32'h00000000;
      rd_q <= 32'h00000000;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      mask_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      mask_q <= mask_d;
      ws_q <= ws_d;
    end
  end

  // card side tracking
  // busy end only at a link rise, so dat0 glitches between edges are ignored
  logic busy_wait_q;
  logic busy_wait_d;
  logic cs_prev_q;
  logic cs_prev_d;
  logic slot_prev_q;
  logic slot_prev_d;
  logic irqs_clr_wr;
  always_comb begin
    stat_d = stat_q;
    busy_wait_d = busy_wait_q;
    cs_prev_d = cmdl_s;
    slot_prev_d = slot_s;
    // RULE_01 command flag
    if (i_cmd_write) begin
      stat_d[card_host_pkg::B_CMD_DONE] = 1'b0;
    end
    if (i_cmd_sent) begin
      stat_d[card_host_pkg::B_CMD_DONE] = 1'b1;
    end
    // RULE_02 receive ready
    if (i_rx_data_read) begin
      stat_d[card_host_pkg::B_RX_RDY] = 1'b0;
    end
    if (i_rx_data_arrive) begin
      stat_d[card_host_pkg::B_RX_RDY] = 1'b1;
    end
    // RULE_03 transmit taken
    if (i_tx_data_write) begin
      stat_d[card_host_pkg::B_TX_TAKEN] = 1'b0;
    end
    if (i_tx_shift_load) begin
      stat_d[card_host_pkg::B_TX_TAKEN] = 1'b1;
    end
    // RULE_05 transfer in progress
    if (i_xfer_start) begin
      stat_d[card_host_pkg::B_XFER] = 1'b1;
    end else if (i_crc_end) begin
      stat_d[card_host_pkg::B_XFER] = 1'b0;
    end
    // RULE_06 RULE_07 busy from response end
    if (i_resp_end) begin
      stat_d[card_host_pkg::B_FREE] = 1'b0;
      busy_wait_d = (i_xfer_kind == card_host_pkg::WR_BLOCKS);
    end
    // RULE_06 dat0 released, sampled on link edge
    if (busy_wait_q && link_rise && dat0_s && !i_resp_end) begin
      stat_d[card_host_pkg::B_FREE] = 1'b1;
      busy_wait_d = 1'b0;
    end
    // RULE_08 RULE_09 RULE_10 read completion
    if ((i_xfer_kind == card_host_pkg::RD_OPEN && i_stop_cmd_end) ||
        (i_xfer_kind == card_host_pkg::RD_SINGLE && i_block_end) ||
        (i_xfer_kind == card_host_pkg::RD_COUNTED && i_block_end && i_last_block)) begin
      stat_d[card_host_pkg::B_FREE] = 1'b1;
    end
    // RULE_11 RULE_12 counter end flags
    if (i_rx_cnt_write) begin
      stat_d[card_host_pkg::B_RX_END] = 1'b0;
    end else if (i_rx_cnt_zero) begin
      stat_d[card_host_pkg::B_RX_END] = 1'b1;
    end
    if (i_tx_cnt_write) begin
      stat_d[card_host_pkg::B_TX_END] = 1'b0;
    end else if (i_tx_cnt_zero) begin
      stat_d[card_host_pkg::B_TX_END] = 1'b1;
    end
    // RULE_13 RULE_14 both counters zero
    stat_d[card_host_pkg::B_RX_FULL] = ~i_rx_cnt_write & i_rx_cnt_zero & i_rx_next_zero;
    stat_d[card_host_pkg::B_TX_EMPTY] = ~i_tx_cnt_write & i_tx_cnt_zero & i_tx_next_zero;
    // RULE_16 read wait level
    stat_d[card_host_pkg::B_RWAIT] = i_io_wait;
    // clear on read first, so a same-cycle event wins
    if (status_read) begin
      stat_d[card_host_pkg::B_BLK_END] = 1'b0;
      stat_d[card_host_pkg::B_SLOT_A] = 1'b0;
      stat_d[card_host_pkg::B_CSEEN] = 1'b0;
    end
    // RULE_04 write block ended
    if (i_block_end && i_xfer_kind == card_host_pkg::WR_BLOCKS) begin
      stat_d[card_host_pkg::B_BLK_END] = 1'b1;
    end
    // RULE_15 slot a interrupt, active low line
    if (!slot_s && slot_prev_q) begin
      stat_d[card_host_pkg::B_SLOT_A] = 1'b1;
    end
    // RULE_17 completion signal, falling cmd line
    if (!cmdl_s && cs_prev_q && stat_q[card_host_pkg::B_CMD_DONE]) begin
      stat_d[card_host_pkg::B_CSEEN] = 1'b1;
    end
    // RULE_18 response index check
    if (i_cmd_write) begin
      stat_d[card_host_pkg::B_RIDX] = 1'b0;
    end
    if (i_resp_end && i_resp_index != i_cmd_index) begin
      stat_d[card_host_pkg::B_RIDX] = 1'b1;
    end
    // RULE_19 unassigned bits zero
    stat_d[31:17] = 15'h0000;
    stat_d[11:9] = 3'h0;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stat_q <= card_host_pkg::STATUS_RESET;
      busy_wait_q <= 1'b0;
      cs_prev_q <= 1'b1;
      slot_prev_q <= 1'b1;
    end else begin
      stat_q <= stat_d;
      busy_wait_q <= busy_wait_d;
      cs_prev_q <= cs_prev_d;
      slot_prev_q <= slot_prev_d;
    end
  end

  // interrupt status: rises of status bits, write one to clear
  assign irqs_clr_wr = wr_fire & (aw_sel == SEL_IRQS);
  always_comb begin
    irqs_d = irqs_q;
    if (irqs_clr_wr) begin
      irqs_d = irqs_q & ~wd_q;
    end
    irqs_d = irqs_d | (stat_d & ~stat_q);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      irqs_q <= 32'h00000000;
    end else begin
      irqs_q <= irqs_d;
    end
  end
  // level output, high while any unmasked bit stands
  assign o_irq = |(irqs_q & mask_q);
  assign o_status = stat_q;
endmodule

// *** bench/card_host_status_flags_sva.sv ***
// checker for the status flag outputs
`timescale 1ns/100ps
module card_host_status_flags_sva (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_cmd_write,
  input wire logic        i_cmd_sent,
  input wire logic        i_resp_end,
  input wire logic [5:0]  i_cmd_index,
  input wire logic [5:0]  i_resp_index,
  input wire logic        i_rx_data_arrive,
  input wire logic        i_tx_data_write,
  input wire logic        i_tx_shift_load,
  input wire logic        i_xfer_start,
  input wire logic        i_crc_end,
  input wire logic        i_io_wait,
  input wire logic        i_rx_cnt_write,
  input wire logic        i_rx_cnt_zero,
  input wire logic        i_tx_cnt_write,
  input wire logic [31:0] o_status
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  chk_cmd_clear: assert property (i_cmd_write && !i_cmd_sent |=> !o_status[0]) else $error("cmd flag kept");
  chk_cmd_set: assert property (i_cmd_sent && !i_cmd_write |=> o_status[0]) else $error("cmd flag not set");
  chk_rx_set: assert property (i_rx_data_arrive |=> o_status[1]) else $error("rx flag not set");
  chk_tx_clear: assert property (i_tx_data_write && !i_tx_shift_load |=> !o_status[2]) else $error("tx kept");
  chk_xfer_end: assert property (i_crc_end && !i_xfer_start |=> !o_status[4]) else $error("xfer kept");
  chk_rx_end_clr: assert property (i_rx_cnt_write && !i_rx_cnt_zero |=> !o_status[6]) else $error("rx end");
  chk_full_clear: assert property (i_rx_cnt_write |=> !o_status[14]) else $error("rx full kept");
  chk_empty_clear: assert property (i_tx_cnt_write |=> !o_status[15]) else $error("tx empty kept");
  chk_wait_follow: assert property (i_io_wait [*2] |-> o_status[12]) else $error("wait bit low");
  chk_index_err: assert property (i_resp_end && !i_cmd_write && (i_cmd_index != i_resp_index)
    |=> o_status[16]) else $error("index error missed");
  chk_unused_zero: assert property (o_status[11:9] == 3'h0 && o_status[25:24] == 2'h0) else $error("bits");
  cover property (i_resp_end ##1 !o_status[5]);
  cover property (o_status[8] && o_status[13]);
  cover property (o_status[14] && o_status[6]);
endmodule
bind card_host_status_flags card_host_status_flags_sva u_sva (.*);

// *** bench/card_model.sv ***
// card side: busy on dat0, slot irq, completion, link clock
`timescale 1ns/100ps
module card_model (
  input  wire logic i_run,
  input  wire logic i_busy,
  input  wire logic i_irq,
  input  wire logic i_done,
  output logic      o_clk,
  output logic      o_dat0,
  output logic      o_cmd,
  output logic      o_dat1
);
  // link clock stands still outside frames
  initial o_clk = 1'b0;
  always #80 o_clk = i_run ? ~o_clk : 1'b0;
  assign o_dat0 = !i_busy;
  // pulled-up lines idle high
  assign o_cmd = !i_done;
  assign o_dat1 = !i_irq;
endmodule

// *** bench/tb_card_host_status_flags.sv ***
// self-checking bench for the card host status flags
`timescale 1ns/100ps
`define CK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t %h %h", $time, g, e); end end
module tb_card_host_status_flags;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rdv;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [1:0]  i_xfer_kind, rrs, brs;
  logic [5:0]  i_cmd_index, i_resp_index, lv;
  logic [12:0] ev;
  logic        run, busy, sirq, done, i0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, o_status;
  wire         i_link_clk, i_dat0, i_cmd_line, i_slot_a_irq, i_last_block, i_io_wait;
  wire         i_rx_cnt_zero, i_rx_next_zero, i_tx_cnt_zero, i_tx_next_zero, i_cmd_write, i_cmd_sent;
  wire         i_resp_end, i_stop_cmd_end, i_rx_data_read, i_rx_data_arrive, i_tx_data_write;
  wire         i_tx_shift_load, i_xfer_start, i_crc_end, i_block_end, i_rx_cnt_write, i_tx_cnt_write;
  int          n_fail = 0;
  int          checks_done = 0;
  assign {i_tx_cnt_write, i_rx_cnt_write, i_block_end, i_crc_end, i_xfer_start, i_tx_shift_load, i_tx_data_write,
    i_rx_data_arrive, i_rx_data_read, i_stop_cmd_end, i_resp_end, i_cmd_sent, i_cmd_write} = ev;
  assign {i_last_block, i_io_wait, i_rx_cnt_zero, i_rx_next_zero, i_tx_cnt_zero, i_tx_next_zero} = lv;
  card_host_status_flags u_dut (.*);
  card_model u_card (.i_run(run), .i_busy(busy), .i_irq(sirq), .i_done(done), .o_clk(i_link_clk),
    .o_dat0(i_dat0), .o_cmd(i_cmd_line), .o_dat1(i_slot_a_irq));
  always #10 i_clk_sys = ~i_clk_sys;
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // one cycle strobe, then let the flag settle
  task pulse(input int b);
    ev[b] <= 1'b1;
    tick(1);
    ev[b] <= 1'b0;
    tick(5);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      tick(1);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    brs = s_axi_bresp;
    if (n == 50) begin
      n_fail++;
      close_out();
    end
    tick(1);
  endtask
  task rd(input logic [31:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      tick(1);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    rdv = s_axi_rdata;
    rrs = s_axi_rresp;
    if (n == 50) begin
      n_fail++;
      close_out();
    end
    tick(1);
  endtask
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, ev, lv, run, busy, sirq, done} = '0;
    s_axi_wstrb = 4'hF;
    i_xfer_kind = 2'h0;
    i_cmd_index = 6'h05;
    i_resp_index = 6'h06;
    tick(3);
    i_rst <= 1'b0;
    tick(2);
    `CK(o_status, card_host_pkg::STATUS_RESET)
    rd(32'h40000050);
    `CK(rrs, card_host_pkg::RESP_SLVERR)
    `CK(rdv, 32'h0)
    wr(card_host_pkg::STATUS_ADDR, 32'hFFFFFFFF);
    `CK(brs, card_host_pkg::RESP_OKAY)
    rd(card_host_pkg::STATUS_ADDR);
    `CK(rdv, card_host_pkg::STATUS_RESET)
    pulse(0);
    `CK(o_status[0], 1'b0)
    pulse(2);
    `CK(o_status[16], 1'b1)
    pulse(1);
    `CK(o_status[0], 1'b1)
    pulse(0);
    `CK(o_status[16], 1'b0)
    i_resp_index <= 6'h05;
    pulse(2);
    `CK(o_status[16], 1'b0)
    i_resp_index <= 6'h06;
    pulse(1);
    pulse(5);
    `CK(o_status[1], 1'b1)
    pulse(4);
    `CK(o_status[1], 1'b0)
    pulse(6);
    `CK(o_status[2], 1'b0)
    pulse(7);
    `CK(o_status[2], 1'b1)
    pulse(8);
    `CK(o_status[4], 1'b1)
    pulse(9);
    `CK(o_status[4], 1'b0)
    // write block end, wait state, card irq and completion together
    i_xfer_kind <= 2'h3;
    lv[4] <= 1'b1;
    sirq <= 1'b1;
    done <= 1'b1;
    pulse(10);
    tick(4);
    `CK(o_status[15:0] & 16'h3108, 16'h3108)
    wr(card_host_pkg::IRQ_MASK_ADDR, 32'h0);
    i0 = o_irq;
    wr(card_host_pkg::IRQ_MASK_ADDR, 32'hFFFFFFFF);
    `CK(i0 ^ o_irq, 1'b1)
    rd(card_host_pkg::STATUS_ADDR);
    `CK(rdv[3], 1'b1)
    `CK(o_status & 32'h2108, 32'h0)
    wr(card_host_pkg::IRQ_STAT_ADDR, 32'hFFFFFFFF);
    `CK(o_irq, 1'b0)
    lv[4] <= 1'b0;
    sirq <= 1'b0;
    done <= 1'b0;
    tick(6);
    `CK(o_status[12], 1'b0)
    // write busy: free only after dat0 released at a link edge
    i_xfer_kind <= 2'h0;
    pulse(10);
    `CK(o_status[5], 1'b1)
    i_xfer_kind <= 2'h3;
    pulse(2);
    `CK(o_status[5], 1'b0)
    busy <= 1'b1;
    run <= 1'b1;
    tick(40);
    `CK(o_status[5], 1'b0)
    busy <= 1'b0;
    tick(40);
    `CK(o_status[5], 1'b1)
    run <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      i_xfer_kind <= 2'(k);
      pulse(2);
      `CK(o_status[5], 1'b0)
      if (k == 1) begin
        pulse(10);
        `CK(o_status[5], 1'b0)
        lv[5] <= 1'b1;
      end
      pulse(k == 2 ? 3 : 10);
      `CK(o_status[5], 1'b1)
      lv[5] <= 1'b0;
    end
    for (int j = 0; j < 2; j++) begin
      lv[3-2*j] <= 1'b1;
      tick(5);
      `CK(o_status[6+j], 1'b1)
      `CK(o_status[14+j], 1'b0)
      lv[2-2*j] <= 1'b1;
      tick(5);
      `CK(o_status[14+j], 1'b1)
      pulse(11 + j);
      lv[3-2*j] <= 1'b0;
      lv[2-2*j] <= 1'b0;
      pulse(11 + j);
      `CK(o_status[6+j], 1'b0)
      `CK(o_status[14+j], 1'b0)
    end
    close_out();
  end
endmodule
